// ===== dv/bwfd_host_model.sv
// host model that sends broadcast write frames on the uart line
`timescale 1ns/100ps
`include "bwfd_regs.svh"
module bwfd_host_model (
	input  wire logic i_core_clk,
	output logic      o_rx
);
	// line idles high between frames, as a uart host keeps it
	initial o_rx = 1'b1;
	task automatic send_bit(input logic b);
		o_rx <= b;
		repeat (`BWFD_BIT_CYC) @(posedge i_core_clk);
	endtask
	////////////////////////////////////////////////////////////////////
	// bad_chk flips check bit 0; header and control faults come from the byte values
	task automatic send_frame(input logic [7:0] hdr, input logic [7:0] ctl,
		input logic [7:0] adr, input logic [31:0] dat, input logic bad_chk);
		logic [7:0] b [8];
		logic [7:0] sum;
		b[0] = hdr;
		b[1] = ctl;
		b[2] = adr;
		for (int i = 0; i < 4; i++) b[3+i] = dat[8*i+:8];
		sum = 8'h00;
		for (int i = 0; i < 7; i++) sum = sum + b[i];
		b[7] = (~sum + `BWFD_CHECK_ADD) ^ {7'h00, bad_chk};
		@(posedge i_core_clk);
		for (int k = 0; k < 8; k++) begin
			send_bit(1'b0);
			for (int j = 0; j < 8; j++) send_bit(b[k][j]);
			send_bit(1'b1);
		end
	endtask
endmodule

// ===== dv/bwfd_top_test.sv
// self-checking bench of the broadcast write frame decoder
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module bwfd_top_test;
	import bwfd_pkg::*;
	logic        i_core_clk = 1'b0;
	logic        i_rstn     = 1'b0;
	logic        rx;
	logic        xr_run     = 1'b1;
	logic        rc_run     = 1'b1;
	logic        src_sel    = 1'b0;
	logic        o_tx, o_tx_oen_n, o_wr_en, o_chk_err, o_mclk_sel, o_mrun;
	logic [11:0] o_wr_addr, got_addr;
	logic [31:0] o_wr_data, got_data;
	logic        tx_bad     = 1'b0;
	int          error_cnt  = 0;
	int          n_checks   = 0;
	int          wr_cnt     = 0;
	int          err_pulse  = 0;
	always #20 i_core_clk = ~i_core_clk;
	bwfd_host_model host (.i_core_clk(i_core_clk), .o_rx(rx));
	bwfd_top dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_rx(rx),
		.i_crystal_derived_clock_run(xr_run),
		.i_rc_oscillator_clock_run(rc_run), .i_src_sel(src_sel),
		.o_tx(o_tx), .o_tx_oen_n(o_tx_oen_n), .o_wr_en(o_wr_en),
		.o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
		.o_chk_err(o_chk_err), .o_metering_clock_sel(o_mclk_sel),
		.o_metering_run(o_mrun));
	////////////////////////////////////////////////////////////////////
	// pulses last one cycle, so they are caught on every edge here
	always @(posedge i_core_clk) begin
		if (i_rstn && (o_tx !== 1'b1 || o_tx_oen_n !== 1'b1)) tx_bad <= 1'b1;
		if (o_wr_en === 1'b1) begin
			wr_cnt++;
			got_addr = o_wr_addr;
			got_data = o_wr_data;
		end
		if (o_chk_err === 1'b1) err_pulse++;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// the write pulse lands in the stop bit, before the send returns
	task automatic frame(input logic [7:0] h, c, a, input logic [31:0] d,
		input logic bad, input int ew, ee, input logic [11:0] xa,
		input logic [31:0] xd);
		int w0;
		int e0;
		w0 = wr_cnt;
		e0 = err_pulse;
		host.send_frame(h, c, a, d, bad);
		`CHK(wr_cnt - w0, ew)
		`CHK(err_pulse - e0, ee)
		if (ew == 1) begin
			`CHK(got_addr, xa)
			`CHK(got_data, xd)
		end
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic reset_values;
		`CHK({o_tx, o_tx_oen_n, o_wr_en, o_chk_err, o_wr_addr, o_wr_data},
			{4'b1100, 44'h0})
	endtask
	// don't-care control bits set high; second frame right behind
	task automatic good_frames;
		frame(8'hfe, 8'hac, 8'h5b, 32'hc3a51e70, 0, 1, 0, 12'ha5b,
			32'hc3a51e70);
		frame(8'hfe, 8'h30, 8'hff, 32'h800100ff, 0, 1, 0, 12'h3ff,
			32'h800100ff);
	endtask
	task automatic bad_check;
		frame(8'hfe, 8'h50, 8'h20, 32'h12345678, 1, 0, 1, 0, 0);
	endtask
	task automatic bad_header;
		frame(8'h7e, 8'h10, 8'h01, 32'h04030201, 0, 0, 0, 0, 0);
	endtask
	task automatic bad_ctrl;
		frame(8'hfe, 8'h21, 8'h02, 32'h00000011, 0, 0, 0, 0, 0);
	endtask
	// run flags are synchronised, so allow a few cycles to settle
	task automatic clock_src;
		for (int k = 0; k < 4; k++) begin
			@(posedge i_core_clk);
			xr_run <= k[0];
			rc_run <= k[1];
			src_sel <= k[0] ^ k[1];
			for (int i = 0; i < 8; i++) begin
				@(posedge i_core_clk);
				if (o_mrun === (k[0] | k[1]) && o_mclk_sel === src_sel) break;
			end
			`CHK(o_mrun, k[0] | k[1])
			`CHK(o_mclk_sel, src_sel)
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (95000) @(posedge i_core_clk);
		error_cnt++;
		$display("mismatch at %0t got %h exp %h", $time, 1'b0, 1'b1);
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		reset_values();
		good_frames();
		bad_check();
		bad_header();
		bad_ctrl();
		clock_src();
		`CHK(tx_bad, 1'b0)
		wrap_up();
	end
endmodule

// ===== rtl/bwfd_pkg.sv
// types of the broadcast write frame decoder
package bwfd_pkg;
	typedef enum logic [1:0] {
		BWFD_RX_IDLE  = 2'b00,
		BWFD_RX_START = 2'b01,
		BWFD_RX_DATA  = 2'b10,
		BWFD_RX_STOP  = 2'b11
	} bwfd_rx_state_t;
	typedef enum logic [0:0] {
		BWFD_SRC_XTAL = 1'b0,
		BWFD_SRC_RC   = 1'b1
	} bwfd_src_t;
endpackage

// ===== rtl/bwfd_regs.svh
// constants of the broadcast write frame decoder
//
// Overview of operation
// - frame is eight bytes: header to check
// - device writes register, never sends reply
// - each byte shifted in lsb first
// - data bytes little endian, low byte first
// - check equals inverted seven-byte sum plus 0x33
// - metering clock from crystal or rc source
// - both sources stopped halts metering logic
`ifndef BWFD_REGS_SVH
`define BWFD_REGS_SVH

`define BWFD_FRAME_BYTES   4'h8
`define BWFD_HEADER_BYTE   8'hfe
`define BWFD_CHECK_ADD     8'h33
`define BWFD_CTRL_LOW_MASK 8'h03
`define BWFD_CTRL_LOW_VAL  8'h00
`define BWFD_CLK_MHZ       25
`define BWFD_BIT_NS        8680
`define BWFD_BIT_CYC       ((`BWFD_BIT_NS * `BWFD_CLK_MHZ) / 1000)
`define BWFD_HALF_CYC      (`BWFD_BIT_CYC / 2)
// must outlast one byte on the line (2170 cycles), or every frame aborts
`define BWFD_STOP_TIMEOUT  16'h1000

`endif

// ===== rtl/bwfd_top.sv
// broadcast write frame decoder with metering clock source select
`timescale 1ns/100ps
`include "bwfd_regs.svh"
module bwfd_top (
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_rx,
	input  wire logic       i_crystal_derived_clock_run,
	input  wire logic       i_rc_oscillator_clock_run,
	input  wire logic       i_src_sel,
	output logic            o_tx,
	output logic            o_tx_oen_n,
	output logic            o_wr_en,
	output logic      [11:0] o_wr_addr,
	output logic      [31:0] o_wr_data,
	output logic            o_chk_err,
	output logic            o_metering_clock_sel,
	output logic            o_metering_run
);
	import bwfd_pkg::*;

	localparam logic [3:0]  LAST_IDX = `BWFD_FRAME_BYTES - 4'h1;
	localparam logic [15:0] GAP_MAX  = `BWFD_STOP_TIMEOUT;

	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic        rx_ferr;
	logic [3:0]  idx_reg;
	logic [7:0]  sum_reg;
	logic [7:0]  buf_reg [0:6];
	logic [15:0] gap_reg;
	logic [2:0]  xs_reg;
	logic [2:0]  rs_reg;
	logic        xrun_reg;
	logic        rrun_reg;

	////////////////////////////////////////////////////////////////////////
	bwfd_uart_rx u_rx (
		.i_core_clk   (i_core_clk),
		.i_rstn       (i_rstn),
		.i_rx         (i_rx),
		.o_byte       (rx_byte),
		.o_byte_valid (rx_valid),
		.o_frame_err  (rx_ferr)
	);

	////////////////////////////////////////////////////////////////////////
	// decode
	wire       is_last   = (idx_reg == LAST_IDX);
	wire [7:0] expect_ck = ~sum_reg + `BWFD_CHECK_ADD;
	wire       hdr_ok    = (rx_byte == `BWFD_HEADER_BYTE);
	wire       ctl_ok    = ((rx_byte & `BWFD_CTRL_LOW_MASK)
	                        == `BWFD_CTRL_LOW_VAL);
	wire       byte_ok   = (idx_reg == 4'h0) ? hdr_ok :
	                       (idx_reg == 4'h1) ? ctl_ok : 1'b1;
	wire       ck_ok     = (rx_byte == expect_ck);
	wire       gap_out   = (gap_reg == GAP_MAX);
	wire [11:0] addr_w   = {buf_reg[1][7:4], buf_reg[2]};
	wire [31:0] data_w   = {buf_reg[6], buf_reg[5],
	                        buf_reg[4], buf_reg[3]};

	// idle gap between bytes resynchronises a broken frame
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || rx_valid || idx_reg == 4'h0) begin
			gap_reg <= 16'h0000;
		end else if (!gap_out) begin
			gap_reg <= gap_reg + 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			idx_reg   <= 4'h0;
			sum_reg   <= 8'h00;
			o_wr_en   <= 1'b0;
			o_wr_addr <= 12'h000;
			o_wr_data <= 32'h0000_0000;
			o_chk_err <= 1'b0;
		end else begin
			o_wr_en   <= 1'b0;
			o_chk_err <= 1'b0;
			if (rx_ferr || (gap_out && rx_valid == 1'b0)) begin
				idx_reg <= 4'h0;
				sum_reg <= 8'h00;
			end else if (rx_valid) begin
				if (is_last) begin
					idx_reg   <= 4'h0;
					sum_reg   <= 8'h00;
					o_wr_en   <= ck_ok;
					o_chk_err <= !ck_ok;
					o_wr_addr <= addr_w;
					o_wr_data <= data_w;
				end else if (byte_ok) begin
					idx_reg <= idx_reg + 4'h1;
					sum_reg <= sum_reg + rx_byte;
				end else begin
					idx_reg <= 4'h0;
					sum_reg <= 8'h00;
				end
			end
		end
	end

	// one generate loop stores the seven checked bytes
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_buf
			always_ff @(posedge i_core_clk) begin
				if (!i_rstn) begin
					buf_reg[gi] <= 8'h00;
				end else if (rx_valid && idx_reg == 4'(gi)) begin
					buf_reg[gi] <= rx_byte;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// no reply ever: the shared line is left released
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_tx       <= 1'b1;
			o_tx_oen_n <= 1'b1;
		end else begin
			o_tx       <= 1'b1;
			o_tx_oen_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator run flags come from other domains
	wire xrun_now = (xs_reg[1] == xs_reg[2]) ? xs_reg[2] : xrun_reg;
	wire rrun_now = (rs_reg[1] == rs_reg[2]) ? rs_reg[2] : rrun_reg;
	wire sel_rc   = (i_src_sel == BWFD_SRC_RC) ? 1'b1 : 1'b0;

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			xs_reg   <= 3'h0;
			rs_reg   <= 3'h0;
			xrun_reg <= 1'b0;
			rrun_reg <= 1'b0;
			o_metering_clock_sel <= 1'b0;
			o_metering_run       <= 1'b0;
		end else begin
			xs_reg   <= {xs_reg[1:0], i_crystal_derived_clock_run};
			rs_reg   <= {rs_reg[1:0], i_rc_oscillator_clock_run};
			xrun_reg <= xrun_now;
			rrun_reg <= rrun_now;
			o_metering_clock_sel <= sel_rc;
			o_metering_run       <= xrun_reg | rrun_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_last_byte;
		rx_valid && is_last && !rx_ferr;
	endsequence

	// an accepted header opens a frame with a fresh running sum
	sequence s_frame_open;
		rx_valid && idx_reg == 4'h0 && hdr_ok;
	endsequence

	sequence s_both_stopped;
		!xrun_reg && !rrun_reg;
	endsequence

	AST_NO_REPLY: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_tx_oen_n && o_tx)
		else $error("device drove the shared line");
	AST_WR_ON_GOOD: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_last_byte and (rx_byte == expect_ck) |=> o_wr_en)
		else $error("good check byte did not write");
	AST_NO_WR_BAD: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_last_byte and (rx_byte != expect_ck) |=> !o_wr_en && o_chk_err)
		else $error("bad check byte wrote");
	AST_WR_ONLY_LAST: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_wr_en |-> $past(rx_valid) && $past(idx_reg) == 4'h7)
		else $error("write not after eighth byte");
	AST_HDR: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		rx_valid && idx_reg == 4'h0 && !hdr_ok |=> idx_reg == 4'h0)
		else $error("bad header advanced frame");
	AST_HDR_OPEN: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_frame_open |=> idx_reg == 4'h1 && sum_reg == `BWFD_HEADER_BYTE)
		else $error("good header did not open a frame");
	AST_CTL_BAD: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		rx_valid && idx_reg == 4'h1 && !ctl_ok |=> idx_reg == 4'h0)
		else $error("bad control byte advanced frame");
	AST_ADDR_MAP: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_last_byte |=> o_wr_addr == $past(addr_w))
		else $error("write address not taken from frame");
	AST_DATA_ORDER: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_wr_en |-> o_wr_data[7:0] == buf_reg[3])
		else $error("data byte order wrong");
	AST_DATA_HIGH: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_wr_en |-> o_wr_data[31:24] == buf_reg[6])
		else $error("high data byte out of place");
	AST_ONE_WRITE: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_wr_en |=> !o_wr_en)
		else $error("write pulse longer than one cycle");
	AST_WR_XOR_ERR: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		!(o_wr_en && o_chk_err))
		else $error("write and check error together");
	AST_IDLE_SUM: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		idx_reg == 4'h0 |-> sum_reg == 8'h00)
		else $error("running sum not cleared between frames");
	AST_SRC: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		##1 o_metering_clock_sel == $past(i_src_sel))
		else $error("clock source select lost");
	AST_STOP: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_both_stopped |=> !o_metering_run)
		else $error("metering ran with both oscillators stopped");
	AST_RUN_ON: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		xrun_reg || rrun_reg |=> o_metering_run)
		else $error("metering stopped with a source running");
endmodule

// ===== rtl/bwfd_uart_rx.sv
// uart byte receiver, lsb first, with three-stage pin sync
`timescale 1ns/100ps
`include "bwfd_regs.svh"
module bwfd_uart_rx (
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_rx,
	output logic      [7:0] o_byte,
	output logic            o_byte_valid,
	output logic            o_frame_err
);
	import bwfd_pkg::*;

	localparam logic [15:0] BIT_CYC  = 16'(`BWFD_BIT_CYC);
	localparam logic [15:0] HALF_CYC = 16'(`BWFD_HALF_CYC);
	// counting down to zero adds a cycle, so reload one short of a bit
	localparam logic [15:0] BIT_LOAD = BIT_CYC - 16'h0001;

	logic [2:0]     sync_reg;
	logic           rx_level_reg;
	bwfd_rx_state_t state_reg;
	logic [15:0]    cnt_reg;
	logic [2:0]     bit_reg;
	logic [7:0]     shift_reg;

	////////////////////////////////////////////////////////////////////////
	// a change counts only once stages two and three agree
	wire agree     = (sync_reg[1] == sync_reg[2]);
	wire rx_now    = agree ? sync_reg[2] : rx_level_reg;
	wire cnt_done  = (cnt_reg == 16'h0000);

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			sync_reg     <= 3'h7;
			rx_level_reg <= 1'b1;
		end else begin
			sync_reg     <= {sync_reg[1:0], i_rx};
			rx_level_reg <= rx_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			state_reg    <= BWFD_RX_IDLE;
			cnt_reg      <= 16'h0000;
			bit_reg      <= 3'h0;
			shift_reg    <= 8'h00;
			o_byte       <= 8'h00;
			o_byte_valid <= 1'b0;
			o_frame_err  <= 1'b0;
		end else begin
			o_byte_valid <= 1'b0;
			o_frame_err  <= 1'b0;
			case (state_reg)
			BWFD_RX_IDLE: begin
				if (!rx_level_reg) begin
					state_reg <= BWFD_RX_START;
					cnt_reg   <= HALF_CYC;
				end
			end
			BWFD_RX_START: begin
				if (cnt_done) begin
					state_reg <= rx_level_reg ? BWFD_RX_IDLE : BWFD_RX_DATA;
					cnt_reg   <= BIT_LOAD;
					bit_reg   <= 3'h0;
				end else begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
			end
			BWFD_RX_DATA: begin
				if (cnt_done) begin
					// first bit lands in bit 7 and walks down to bit 0
					shift_reg <= {rx_level_reg, shift_reg[7:1]};
					cnt_reg   <= BIT_LOAD;
					bit_reg   <= bit_reg + 3'h1;
					if (bit_reg == 3'h7) begin
						state_reg <= BWFD_RX_STOP;
					end
				end else begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
			end
			BWFD_RX_STOP: begin
				if (cnt_done) begin
					state_reg <= BWFD_RX_IDLE;
					o_byte    <= shift_reg;
					o_byte_valid <= rx_level_reg;
					o_frame_err  <= !rx_level_reg;
				end else begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
			end
			default: state_reg <= BWFD_RX_IDLE;
			endcase
		end
	end

	AST_ONE_PULSE: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_byte_valid |-> !o_frame_err)
		else $error("byte valid and framing error together");
endmodule
